// ===== include/adc_ctl_params.svh
`ifndef ADC_CTL_PARAMS_SVH
`define ADC_CTL_PARAMS_SVH

// converter geometry
`define RES_W 10
`define FULL_SCALE 10'h3FF
`define BIP_MIN 10'h200
`define BIP_MAX 10'h1FF
// conversion lengths in converter clock cycles
`define CONV_NORMAL 5'd13
`define CONV_FIRST 5'd25
// default prescale divide of mclk to converter clock
`define PRESCALE_DIV 8'd64
// signature row addresses of the trims
`define SIG_ADDR_GAIN 8'h05
`define SIG_ADDR_OFFSET 8'h03
// signature access window in mclk cycles after arming
`define SIG_WINDOW 2'd3
// temperature sensor channel select code
`define CH_TEMP 5'h0B

`endif

// ===== include/adc_ctl_pkg.sv
package adc_ctl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } conv_state_e;

  // settings latched at conversion start
  typedef struct packed {
    logic [4:0] inputSelect;
    logic bipolar;
  } conv_cfg_s;

  // result path to the user side
  typedef struct packed {
    logic [7:0] lowByte;
    logic [7:0] highByte;
  } result_bytes_s;

endpackage

// ===== core/adc_clk_div.sv
`timescale 1ns/10ps
`include "adc_ctl_params.svh"

// prescaler: one-cycle enable at mclk/divide, held in reset while disabled
module adc_clk_div #(
  parameter logic [7:0] DIV = `PRESCALE_DIV
) (
  input wire logic mclk,  // system clock
  input wire logic rst_n, // async reset
  input wire logic run,   // counts only while set
  output logic tick       // converter clock enable pulse
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_state_s;

  div_state_s st_r;
  div_state_s st_nxt;

  // count and emit a pulse when the count wraps
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt == DIV - 8'h01) begin
      st_nxt.cnt = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule

// ===== core/adc_result_ctl.sv
`timescale 1ns/10ps
`include "adc_ctl_params.svh"
module adc_result_ctl #(
  parameter logic [7:0] PRESCALE = `PRESCALE_DIV, // mclk cycles per converter clock
  parameter logic [7:0] TRIM_GAIN = 8'h80,        // factory gain trim, arbitrary default
  parameter logic [7:0] TRIM_OFFSET = 8'h00       // factory offset trim, arbitrary default
) (
  input wire logic mclk,                     // 200 MHz clock
  input wire logic rst_n,                    // async reset, active low
  input wire logic converterEnable,          // converter on
  input wire logic startWrite,               // pulse: software writes one to start bit
  input wire logic freeRunning,              // auto restart mode
  input wire logic intEnable,                // completion interrupt enable
  input wire logic doneFlagClear,            // pulse: software clears done flag
  input wire logic [4:0] inputSelect,        // channel and gain code
  input wire logic bipolarInputSelect,       // bipolar differential mode
  input wire logic leftAdjustSelect,         // left adjust result
  input wire logic cpuHalted,                // CPU halted in sleep
  input wire logic noiseSleep,               // sleep mode is idle or noise reduction
  input wire logic lowByteRead,              // pulse: low result byte read
  input wire logic highByteRead,             // pulse: high result byte read
  input wire logic [9:0] sarRaw,             // raw analog code, async
  input wire logic sarOver,                  // input above range, async
  input wire logic sarUnder,                 // difference negative, async
  input wire logic sigArm,                   // pulse: signature select and enable written together
  input wire logic sigLoad,                  // pulse: program memory load
  input wire logic [7:0] sigAddr,            // signature row address
  output logic conversionStartBit,           // reads as start bit, high while busy
  output logic conversionDoneFlag,           // sticky done flag
  output logic completeIrq,                  // completion interrupt request level
  output logic [7:0] resultLowByte,          // low result byte
  output logic [7:0] resultHighByte,         // high result byte
  output logic [4:0] activeSelect,           // selection driving the analog mux
  output logic selfProgramEnable,            // busy during signature access
  output logic [7:0] sigData,                // returned trim byte
  output logic sigValid                      // pulse: sigData valid
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    adc_ctl_pkg::conv_state_e state;
    adc_ctl_pkg::conv_cfg_s cfg;
    logic [4:0] cycles;
    logic firstDone;
    logic startBit;
    logic doneFlag;
    logic irq;
    logic sleepArmed;
    logic blocked;
    logic [9:0] result;
    logic [7:0] lowOut;
    logic [7:0] highOut;
    logic self_program_enable;
    logic [1:0] sigWin;
    logic [7:0] sigData;
    logic sigValid;
  } ctl_state_s;

  ctl_state_s st_r;
  ctl_state_s st_nxt;
  logic tick;
  // synchroniser stages, over-range bit on top of the code
  logic [10:0] rawSync1_r;
  logic [10:0] rawSync2_r;
  logic underSync1_r;
  logic underSync2_r;
  // formatted view of the analog code and of the stored result
  logic [9:0] coded;
  logic differential;
  adc_ctl_pkg::result_bytes_s bytes;

  // ----------------------------------------
  // converter clock enable
  // ----------------------------------------
  // prescaler restarts from zero whenever the converter is switched off
  adc_clk_div #(
    .DIV(PRESCALE)
  ) u_div (
    .mclk(mclk),
    .rst_n(rst_n),
    .run(converterEnable),
    .tick(tick)
  );

  // ----------------------------------------
  // analog input synchronisers
  // ----------------------------------------
  // two stages; the converter holds the raw code steady long before it is used
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rawSync1_r <= '0;
      rawSync2_r <= '0;
      underSync1_r <= 1'b0;
      underSync2_r <= 1'b0;
    end else begin
      rawSync1_r <= {sarOver, sarRaw};
      rawSync2_r <= rawSync1_r;
      underSync1_r <= sarUnder;
      underSync2_r <= underSync1_r;
    end
  end

  // ----------------------------------------
  // result coding
  // ----------------------------------------
  // bit four of the selection marks a differential pair
  assign differential = st_r.cfg.inputSelect[4];

  // encode per conversion type
  always_comb begin
    coded = rawSync2_r[9:0];
    if (!differential) begin
      // single-ended: over range pins at full scale
      if (rawSync2_r[10]) begin
        coded = `FULL_SCALE;
      end
    end else if (!st_r.cfg.bipolar) begin
      // unipolar differential: a negative difference clamps to zero
      if (underSync2_r) begin
        coded = 10'h000;
      end else if (rawSync2_r[10]) begin
        coded = `FULL_SCALE;
      end
    end else if (rawSync2_r[10]) begin
      // bipolar: over range goes to the end code matching the sign
      coded = underSync2_r ? `BIP_MIN : `BIP_MAX;
    end
  end

  // byte placement, adjust applies immediately
  // the sign bit lands in high byte bit one, or bit seven when left adjusted
  always_comb begin
    if (leftAdjustSelect) begin
      bytes.highByte = st_r.result[9:2];
      bytes.lowByte = {st_r.result[1:0], 6'h00};
    end else begin
      bytes.highByte = {6'h00, st_r.result[9:8]};
      bytes.lowByte = st_r.result[7:0];
    end
  end

  // ----------------------------------------
  // control
  // ----------------------------------------
  always_comb begin
    // hold by default; the trim strobe falls back to zero
    st_nxt = st_r;
    st_nxt.sigValid = 1'b0;
    st_nxt.lowOut = bytes.lowByte;
    st_nxt.highOut = bytes.highByte;
    // sticky flag, set beats clear below
    if (doneFlagClear) begin
      st_nxt.doneFlag = 1'b0;
    end

    // a start write is ignored while the converter is off
    if (startWrite && converterEnable) begin
      st_nxt.startBit = 1'b1;
    end

    // noise canceler arm, enabled only while noiseSleep marks idle or noise reduction sleep
    // one shot per halt, so a finished sleep conversion does not start another
    if (converterEnable && st_r.state == adc_ctl_pkg::ST_IDLE && !st_r.startBit && !freeRunning && intEnable &&
        noiseSleep && cpuHalted && !st_r.sleepArmed) begin
      st_nxt.startBit = 1'b1;
      st_nxt.sleepArmed = 1'b1;
    end
    // the one shot rearms once the CPU runs and no conversion is in flight
    if (!cpuHalted && st_r.state == adc_ctl_pkg::ST_IDLE) begin
      st_nxt.sleepArmed = 1'b0;
    end

    // a low byte read locks both bytes; it wins over a release in the same cycle
    if (highByteRead) begin
      st_nxt.blocked = 1'b0;
    end
    if (lowByteRead) begin
      st_nxt.blocked = 1'b1;
    end

    // conversion sequencer on converter clock
    // switching off drops any conversion and makes the next one a long first conversion
    if (!converterEnable) begin
      st_nxt.state = adc_ctl_pkg::ST_IDLE;
      st_nxt.startBit = 1'b0;
      st_nxt.firstDone = 1'b0;
      st_nxt.cfg.inputSelect = inputSelect;
      st_nxt.cfg.bipolar = bipolarInputSelect;
    end else if (tick) begin
      unique case (st_r.state)
        adc_ctl_pkg::ST_IDLE: begin
          // selection follows freely until start
          st_nxt.cfg.inputSelect = inputSelect;
          st_nxt.cfg.bipolar = bipolarInputSelect;
          if (st_r.startBit) begin
            // the first conversion after enable needs the long count to settle the analog side
            st_nxt.state = adc_ctl_pkg::ST_CONV;
            st_nxt.cycles = st_r.firstDone ? `CONV_NORMAL - 5'd1 : `CONV_FIRST - 5'd1;
          end
        end
        adc_ctl_pkg::ST_CONV: begin
          // count down; the last tick hands over to the completion state
          if (st_r.cycles == 5'd1) begin
            st_nxt.state = adc_ctl_pkg::ST_DONE;
          end
          st_nxt.cycles = st_r.cycles - 5'd1;
        end
        adc_ctl_pkg::ST_DONE: begin
          // completion: store unless blocked, flag always, irq only when intEnable is set
          if (!st_r.blocked && !lowByteRead) begin
            st_nxt.result = coded;
          end
          st_nxt.doneFlag = 1'b1;
          st_nxt.firstDone = 1'b1;
          // next conversion samples the selection present now
          st_nxt.cfg.inputSelect = inputSelect;
          st_nxt.cfg.bipolar = bipolarInputSelect;
          if (freeRunning) begin
            st_nxt.state = adc_ctl_pkg::ST_CONV;
            st_nxt.cycles = `CONV_NORMAL - 5'd1;
          end else begin
            st_nxt.state = adc_ctl_pkg::ST_IDLE;
            st_nxt.startBit = 1'b0;
          end
        end
        default: begin
          // the unused state code recovers to idle
          st_nxt.state = adc_ctl_pkg::ST_IDLE;
        end
      endcase
    end

    // interrupt request regardless of what woke the CPU
    st_nxt.irq = st_nxt.doneFlag && intEnable;

    // signature row access
    // arming opens a three-cycle window; a load inside it returns the trim byte
    if (sigArm && !st_r.self_program_enable) begin
      st_nxt.self_program_enable = 1'b1;
      st_nxt.sigWin = `SIG_WINDOW;
    end else if (st_r.self_program_enable) begin
      if (sigLoad) begin
        st_nxt.self_program_enable = 1'b0;
        st_nxt.sigValid = 1'b1;
        st_nxt.sigData = (sigAddr == `SIG_ADDR_GAIN) ? TRIM_GAIN :
                         (sigAddr == `SIG_ADDR_OFFSET) ? TRIM_OFFSET : 8'h00;
      end else if (st_r.sigWin == 2'd1) begin
        // no load arrived, the window closes by itself
        st_nxt.self_program_enable = 1'b0;
      end
      st_nxt.sigWin = st_r.sigWin - 2'd1;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // one register for the whole control state; reset clears every field
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a register field, no logic after the flops
  assign conversionStartBit = st_r.startBit;
  assign conversionDoneFlag = st_r.doneFlag;
  assign completeIrq = st_r.irq;
  assign resultLowByte = st_r.lowOut;
  assign resultHighByte = st_r.highOut;
  assign activeSelect = st_r.cfg.inputSelect;
  assign selfProgramEnable = st_r.self_program_enable;
  assign sigData = st_r.sigData;
  assign sigValid = st_r.sigValid;

endmodule

// ===== tb/adc_ctl_assertions.sv
`timescale 1ns/10ps
// ------------
// port checker
// ------------
module adc_ctl_checker (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic intEnable, // irq on
  input wire logic doneFlagClear, // clear
  input wire logic leftAdjustSelect, // adjust
  input wire logic lowByteRead, // low read
  input wire logic highByteRead, // high read
  input wire logic sigLoad, // load
  input wire logic conversionStartBit, // busy
  input wire logic conversionDoneFlag, // done
  input wire logic completeIrq, // irq
  input wire logic [7:0] resultLowByte, // low
  input wire logic [7:0] resultHighByte, // high
  input wire logic selfProgramEnable, // sig busy
  input wire logic sigValid // sig valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic blocked_r;
  // set by a low byte read, freed by the high byte read
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) blocked_r <= 1'b0;
    else if (highByteRead) blocked_r <= 1'b0;
    else if (lowByteRead) blocked_r <= 1'b1;
  end
  busy_done_a: assert property ($fell(conversionStartBit) |-> ##[0:2] conversionDoneFlag)
    else $error("busy ended without done");
  irq_on_a: assert property (conversionDoneFlag && $past(intEnable) |-> completeIrq)
    else $error("irq missing");
  irq_cause_a: assert property (completeIrq |-> conversionDoneFlag && $past(intEnable))
    else $error("irq without cause");
  flag_sticky_a: assert property (conversionDoneFlag && !doneFlagClear |=> conversionDoneFlag)
    else $error("done flag lost");
  right_adjust_a: assert property (!leftAdjustSelect && !$past(leftAdjustSelect) |-> resultHighByte[7:2] == 6'h00)
    else $error("right adjust broken");
  hold_blocked_a: assert property (blocked_r && !highByteRead && $stable(leftAdjustSelect)
    |=> $stable({resultHighByte, resultLowByte}))
    else $error("blocked result moved");
  sig_cause_a: assert property (sigValid |-> $past(sigLoad && selfProgramEnable) && !selfProgramEnable)
    else $error("trim byte without load");
  sig_window_a: assert property ($rose(selfProgramEnable) |-> ##[1:4] !selfProgramEnable)
    else $error("signature access stuck");
  cover property (conversionDoneFlag && completeIrq);
  cover property (blocked_r && conversionDoneFlag);
  cover property (sigValid);
endmodule
bind adc_result_ctl adc_ctl_checker adc_ctl_checker_inst (.mclk, .rst_n, .intEnable, .doneFlagClear,
  .leftAdjustSelect, .lowByteRead, .highByteRead, .sigLoad, .conversionStartBit, .conversionDoneFlag,
  .completeIrq, .resultLowByte, .resultHighByte, .selfProgramEnable, .sigValid);

// ===== tb/analog_src.sv
`timescale 1ns/10ps
// -------------
// analog source
// -------------
module analog_src (
  input wire logic [11:0] level, // over, under, code
  output logic [9:0] sarRaw, // code
  output logic sarOver, // above range
  output logic sarUnder // below zero
);
  // levels settle after the bench moves them, never on an edge
  assign #1 {sarOver, sarUnder, sarRaw} = level;
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
`include "adc_ctl_params.svh"
// -----
// bench
// -----
module tb;
  logic mclk = 1'h0, rst_n = 1'h0, converterEnable = 1'h0, startWrite = 1'h0, freeRunning = 1'h0;
  logic intEnable = 1'h0, doneFlagClear = 1'h0, bipolarInputSelect = 1'h0, leftAdjustSelect = 1'h0;
  logic cpuHalted = 1'h0, noiseSleep = 1'h0, lowByteRead = 1'h0, highByteRead = 1'h0;
  logic sigArm = 1'h0, sigLoad = 1'h0;
  logic [4:0] inputSelect = 5'h00;
  logic [7:0] sigAddr = 8'h00;
  logic [11:0] level = 12'h000;
  logic [9:0] sarRaw, last;
  logic sarOver, sarUnder, conversionStartBit, conversionDoneFlag, completeIrq, selfProgramEnable, sigValid;
  logic [7:0] resultLowByte, resultHighByte, sigData;
  logic [4:0] activeSelect;
  logic [7:0] adr [3] = '{`SIG_ADDR_GAIN, `SIG_ADDR_OFFSET, 8'h07};
  logic [7:0] trim [3] = '{8'h9A, 8'hF3, 8'h00}; // trims are arbitrary
  int fail_count = 0, n_checks = 0, cycles = 0;
  int expQ[$];
  adc_result_ctl #(.PRESCALE(8'h02), .TRIM_GAIN(8'h9A), .TRIM_OFFSET(8'hF3)) adc_result_ctl_inst (
    .mclk, .rst_n, .converterEnable, .startWrite, .freeRunning, .intEnable, .doneFlagClear, .inputSelect,
    .bipolarInputSelect, .leftAdjustSelect, .cpuHalted, .noiseSleep, .lowByteRead, .highByteRead, .sarRaw,
    .sarOver, .sarUnder, .sigArm, .sigLoad, .sigAddr, .conversionStartBit, .conversionDoneFlag, .completeIrq,
    .resultLowByte, .resultHighByte, .activeSelect, .selfProgramEnable, .sigData, .sigValid);
  analog_src analog_src_inst (.level, .sarRaw, .sarOver, .sarUnder);
  // clock and run limit
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      finish_test();
    end
  end
  // reference result from mode and analog level
  function automatic logic [9:0] expect_res(input logic [4:0] sel, input logic bip, input logic [11:0] lv);
    if (sel[4] && bip) return lv[11] ? (lv[10] ? 10'h200 : 10'h1FF) : lv[9:0];
    if (lv[11]) return 10'h3FF;
    return (sel[4] && lv[10]) ? 10'h000 : lv[9:0];
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_done();
    repeat (300) begin
      @(negedge mclk);
      if (conversionDoneFlag === 1'h1) break;
    end
    check(16'(conversionDoneFlag), 16'h0001);
  endtask
  task automatic clear_flag();
    @(posedge mclk) doneFlagClear <= 1'h1;
    @(posedge mclk) doneFlagClear <= 1'h0;
  endtask
  // one single conversion; a blocked one must leave the old result
  task automatic convert(input logic [11:0] lv, input logic blk);
    logic [9:0] e;
    level <= lv;
    expQ.push_back(int'(blk ? last : expect_res(inputSelect, bipolarInputSelect, lv)));
    @(posedge mclk) startWrite <= 1'h1;
    @(posedge mclk) startWrite <= 1'h0;
    wait_done();
    repeat (3) @(negedge mclk);
    e = 10'(expQ.pop_front());
    check({resultHighByte, resultLowByte}, leftAdjustSelect ? {e, 6'h00} : {6'h00, e});
    check(16'(completeIrq), 16'(intEnable));
    last = e;
    clear_flag();
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h441232fb));
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    // the reference never switches here, so no result has to be discarded
    @(posedge mclk) converterEnable <= 1'h1;
    intEnable <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      inputSelect <= i[0] ? {1'h1, 4'(i * 5 / 2)} : `CH_TEMP;
      bipolarInputSelect <= i[1];
      leftAdjustSelect <= i[2];
      @(posedge mclk);
      convert({1'(i == 3 || i == 4), 1'(i == 3 || i == 5 || i == 6), 10'($urandom)}, 1'h0);
    end
    leftAdjustSelect <= 1'h0;
    @(posedge mclk) lowByteRead <= 1'h1;
    @(posedge mclk) lowByteRead <= 1'h0;
    convert(12'h2AA, 1'h1);
    @(posedge mclk) highByteRead <= 1'h1;
    @(posedge mclk) highByteRead <= 1'h0;
    convert(12'h0D5, 1'h0);
    inputSelect <= 5'h01;
    freeRunning <= 1'h1;
    @(posedge mclk) startWrite <= 1'h1;
    @(posedge mclk) startWrite <= 1'h0;
    wait_done();
    @(posedge mclk) inputSelect <= 5'h02;
    clear_flag();
    @(negedge mclk);
    check(16'(activeSelect), 16'h0001);
    wait_done();
    repeat (2) @(negedge mclk);
    check(16'(activeSelect), 16'h0002);
    @(posedge mclk) freeRunning <= 1'h0;
    clear_flag();
    wait_done();
    repeat (2) @(negedge mclk);
    check(16'(conversionStartBit), 16'h0000);
    clear_flag();
    intEnable <= 1'h0;
    noiseSleep <= 1'h1;
    cpuHalted <= 1'h1;
    repeat (100) @(negedge mclk);
    check(16'(conversionStartBit), 16'h0000);
    @(posedge mclk) cpuHalted <= 1'h0;
    intEnable <= 1'h1;
    @(posedge mclk) cpuHalted <= 1'h1;
    // another wake-up source ends the halt while the conversion runs
    repeat (10) @(posedge mclk);
    cpuHalted <= 1'h0;
    wait_done();
    @(negedge mclk);
    check(16'(completeIrq), 16'h0001);
    @(posedge mclk) noiseSleep <= 1'h0;
    clear_flag();
    @(negedge mclk);
    for (int k = 0; k < 3; k++) begin
      check(16'(selfProgramEnable), 16'h0000);
      @(posedge mclk) sigAddr <= adr[k];
      sigArm <= 1'h1;
      @(posedge mclk) sigArm <= 1'h0;
      sigLoad <= 1'h1;
      @(posedge mclk) sigLoad <= 1'h0;
      @(negedge mclk);
      check({7'h00, sigValid, sigData}, {8'h01, trim[k]});
    end
    finish_test();
  end
endmodule
